// File: hdl/hsc_pkg.sv
// Purpose: Shared constants for the halt and standby controller.
// Assumes: One 200 MHz core clock, synchronous active-high reset.
// Notes:   Register offsets are byte addresses on the plain register port.
package hsc_pkg;

   // Register map
   localparam logic [15:0] HSC_MODE_ADDR   = 16'hffd2;   // Halt / watchdog mode register
   localparam logic [15:0] HSC_FCLR_ADDR   = 16'hffc3;   // Request flag clear address
   localparam logic [15:0] HSC_CFG_ADDR    = 16'hffd1;   // Ext irq zero config register
   localparam logic [15:0] HSC_STAT_ADDR   = 16'hffc2;   // Request flag status (read)
   localparam logic [15:0] HSC_RXBUF_ADDR  = 16'hffeb;   // Serial receive buffer (read)

   // Field positions in the mode and config registers
   localparam int HSC_PIN_HOLD_BIT  = 0;   // Pin hold in stop
   localparam int HSC_SEL_LO_BIT    = 2;   // Standby select low
   localparam int HSC_SEL_HI_BIT    = 3;   // Standby select high
   localparam int HSC_WARM_BIT      = 4;   // Warm-up length select
   localparam int HSC_EDGE_BIT      = 0;   // Edge select in config register

   // Reset values
   localparam logic [7:0] HSC_MODE_RST = 8'h00;
   localparam logic [7:0] HSC_CFG_RST  = 8'h00;

   // Flag-clear codes (vector divided by eight)
   localparam logic [7:0] HSC_CLR_EXT0 = 8'h05;
   localparam logic [7:0] HSC_CLR_RX   = 8'h0e;

   // Request flag positions in the status byte
   localparam int HSC_ST_EXT0 = 0;
   localparam int HSC_ST_RX   = 1;

   // Warm-up lengths in oscillator periods
   localparam int HSC_WARM_SHORT = 16384;   // Two to the fourteenth
   localparam int HSC_WARM_LONG  = 65536;   // Two to the sixteenth
   localparam int HSC_CNT_W      = 17;

   // Standby modes
   typedef enum logic [1:0] {
      HSC_RUN   = 2'b00,
      HSC_STOP  = 2'b01,
      HSC_DEEP  = 2'b10,
      HSC_LIGHT = 2'b11
   } hsc_mode_t;

   // Controller states
   typedef enum logic [1:0] {
      HSC_S_ACTIVE = 2'b00,
      HSC_S_HALT   = 2'b01,
      HSC_S_WARM   = 2'b10
   } hsc_state_t;

endpackage

// File: hdl/hsc_sync.sv
// Purpose: Two-flop synchroniser for a single level.
// Assumes: Input comes from outside the core clock domain.
// Notes:   First stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none
module hsc_sync (
   input  wire logic core_clk,   // Core clock
   input  wire logic rst,        // Synchronous reset
   input  wire logic async_in,   // Unsynchronised level
   output logic      sync_out    // Synchronised level
);
   logic meta_r;   // First stage, read only by second stage

   // Two stages to settle metastability
   always_ff @(posedge core_clk) begin
      if (rst) begin
         meta_r   <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         meta_r   <= async_in;
         sync_out <= meta_r;
      end
   end
endmodule
`default_nettype wire

// File: hdl/hsc_warmup.sv
// Purpose: Oscillator warm-up counter for stop-mode exit.
// Assumes: Start is a one-cycle pulse; counts core clocks as oscillator periods.
// Notes:   Done pulses once when the chosen count has elapsed.
`timescale 1ns/1ps
`default_nettype none
module hsc_warmup #(
   parameter int SHORT_CNT = hsc_pkg::HSC_WARM_SHORT,   // Count with select clear
   parameter int LONG_CNT  = hsc_pkg::HSC_WARM_LONG     // Count with select set
) (
   input  wire logic core_clk,   // Core clock
   input  wire logic rst,        // Synchronous reset
   input  wire logic start,      // Begin counting
   input  wire logic long_sel,   // Pick the long count
   input  wire logic abort,      // Drop a running count
   output logic      busy,       // Counting in progress
   output logic      done        // One-cycle end pulse
);
   logic [hsc_pkg::HSC_CNT_W-1:0] cnt_r;     // Remaining periods
   logic [hsc_pkg::HSC_CNT_W-1:0] load_val;  // Chosen length
   logic                          last;      // Final period

   assign load_val = long_sel ? hsc_pkg::HSC_CNT_W'(LONG_CNT)
                              : hsc_pkg::HSC_CNT_W'(SHORT_CNT);
   assign last     = busy && (cnt_r == hsc_pkg::HSC_CNT_W'(1));

   // Load on start, count down, flag the end
   always_ff @(posedge core_clk) begin
      if (rst || abort) begin
         cnt_r <= '0;
         busy  <= 1'b0;
         done  <= 1'b0;
      end else if (start) begin
         cnt_r <= load_val;
         busy  <= 1'b1;
         done  <= 1'b0;
      end else begin
         cnt_r <= busy ? cnt_r - hsc_pkg::HSC_CNT_W'(1) : cnt_r;
         busy  <= busy && !last;
         done  <= last;
      end
   end
endmodule
`default_nettype wire

// File: hdl/hsc_top.sv
// Purpose: Halt and standby controller: mode register, wake logic, clock gates.
// Assumes: CPU gives a halt strobe; serial rx is a pulse, other irq lines are levels from peripherals on core_clk,
//          except ext irq zero and nmi, which arrive from pins.
// Notes:   Reset exits stop with no warm-up; the warm-up counts are parameters.
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module hsc_top #(
   parameter int WARM_SHORT = hsc_pkg::HSC_WARM_SHORT,   // Short warm-up, cycles
   parameter int WARM_LONG  = hsc_pkg::HSC_WARM_LONG     // Long warm-up, cycles
) (
   input  wire logic        core_clk,        // Core clock
   input  wire logic        rst,             // Synchronous reset, active high
   // Register port
   input  wire logic [15:0] reg_addr,        // Byte address
   input  wire logic [7:0]  reg_wdata,       // Write data
   input  wire logic        reg_wr,          // Write strobe
   input  wire logic        reg_rd,          // Read strobe
   output logic      [7:0]  reg_rdata,       // Read data, cycle after strobe
   // CPU side
   input  wire logic        halt_req,        // Halt instruction strobe
   input  wire logic        irq_enabled,     // CPU interrupt enable state
   output logic             wake,            // Halt released, one cycle
   output logic             wake_service,    // Wake will be serviced
   output logic             halted,          // CPU held in halt
   // Interrupt sources
   input  wire logic        nmi_pin,         // Non-maskable request pin
   input  wire logic        ext_irq_zero,    // Ext irq zero pin
   input  wire logic        ext_irq_one,     // Ext irq one, same domain
   input  wire logic        watchdog_irq,    // Watchdog request
   input  wire logic        timer_irqs,      // Any timer request
   input  wire logic        serial_rx_irq,   // Receive complete pulse
   input  wire logic        serial_tx_irq,   // Transmit complete
   input  wire logic        irq_ack_ext0,    // CPU acknowledged ext zero
   // Clock and pin controls
   output logic             cpu_clk_en,      // CPU and general units clock
   output logic             timer_clk_en,    // Eight-bit timers clock
   output logic             serial_clk_en,   // Serial interface clock
   output logic             wdog_clk_en,     // Watchdog clock
   output logic             osc_run,         // Oscillator enabled
   output logic             clk_pin_high,    // Force clock output pin to one
   output logic             pins_float,      // Put ordinary pins in high impedance
   output logic             pins_hold        // Freeze output pins at pre-halt levels
);
   // Registers
   logic [7:0]             mode_r;      // Mode register
   logic [7:0]             cfg_r;       // Ext irq zero config
   logic                   ext0_flag_r; // Ext zero edge request latch
   logic                   rx_flag_r;   // Serial receive request
   logic                   ext0_prev_r; // Previous synchronised ext zero
   logic                   nmi_prev_r;  // Previous synchronised nmi
   hsc_pkg::hsc_state_t    state_r;     // Controller state
   hsc_pkg::hsc_state_t    state_nxt;
   hsc_pkg::hsc_mode_t     halt_mode_r; // Mode latched at halt entry

   // Synchronised pins
   logic ext0_s;
   logic nmi_s;

   hsc_sync u_sync_ext0 (
      .core_clk (core_clk),
      .rst      (rst),
      .async_in (ext_irq_zero),
      .sync_out (ext0_s)
   );

   hsc_sync u_sync_nmi (
      .core_clk (core_clk),
      .rst      (rst),
      .async_in (nmi_pin),
      .sync_out (nmi_s)
   );

   // Field decode
   hsc_pkg::hsc_mode_t sel_mode;
   logic               edge_mode;
   logic               hold_en;
   logic               warm_long;
   assign sel_mode  = hsc_pkg::hsc_mode_t'({mode_r[hsc_pkg::HSC_SEL_HI_BIT],
                                            mode_r[hsc_pkg::HSC_SEL_LO_BIT]});
   assign edge_mode = cfg_r[hsc_pkg::HSC_EDGE_BIT];
   assign hold_en   = mode_r[hsc_pkg::HSC_PIN_HOLD_BIT];
   assign warm_long = mode_r[hsc_pkg::HSC_WARM_BIT];

   // Address decode
   logic wr_mode;
   logic wr_cfg;
   logic wr_fclr;
   logic rd_rxbuf;
   assign wr_mode  = reg_wr && (reg_addr == hsc_pkg::HSC_MODE_ADDR);
   assign wr_cfg   = reg_wr && (reg_addr == hsc_pkg::HSC_CFG_ADDR);
   assign wr_fclr  = reg_wr && (reg_addr == hsc_pkg::HSC_FCLR_ADDR);
   assign rd_rxbuf = reg_rd && (reg_addr == hsc_pkg::HSC_RXBUF_ADDR);

   // Ext zero request: edge mode uses the latch, level mode reads the pin
   logic ext0_rise;
   logic ext0_req;
   logic ext0_clr;
   logic to_level;
   assign ext0_rise = ext0_s && !ext0_prev_r;
   assign to_level  = wr_cfg && edge_mode && !reg_wdata[hsc_pkg::HSC_EDGE_BIT];
   assign ext0_clr  = (wr_fclr && (reg_wdata == hsc_pkg::HSC_CLR_EXT0)) || irq_ack_ext0;
   assign ext0_req  = edge_mode ? ext0_flag_r : ext0_s;

   // Nmi is a falling-edge request
   logic nmi_req;
   assign nmi_req = !nmi_s && nmi_prev_r;

   // Wake source selection per latched mode
   logic any_maskable;
   logic deep_sources;
   logic wake_hit;
   logic maskable_hit;
   logic deep_or_stop;
   assign deep_or_stop = (halt_mode_r == hsc_pkg::HSC_DEEP) ||
                         (halt_mode_r == hsc_pkg::HSC_STOP);
   // Watchdog never wakes deep idle or stop
   assign any_maskable = ext0_req || ext_irq_one || watchdog_irq || timer_irqs ||
                         rx_flag_r || serial_tx_irq;
   assign deep_sources = ext0_req;
   assign maskable_hit = deep_or_stop ? deep_sources : any_maskable;
   assign wake_hit     = nmi_req || maskable_hit;

   // Stop warm-up
   logic warm_start;
   logic warm_done;
   logic warm_busy;
   assign warm_start = (state_r == hsc_pkg::HSC_S_HALT) && wake_hit &&
                       (halt_mode_r == hsc_pkg::HSC_STOP);

   hsc_warmup #(
      .SHORT_CNT (WARM_SHORT),
      .LONG_CNT  (WARM_LONG)
   ) u_warm (
      .core_clk (core_clk),
      .rst      (rst),
      .start    (warm_start),
      .long_sel (warm_long),
      .abort    (1'b0),
      .busy     (warm_busy),
      .done     (warm_done)
   );

   // Next state
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         hsc_pkg::HSC_S_ACTIVE: begin
            // A pending flag ends the halt at once
            if (halt_req && !wake_hit) begin
               state_nxt = hsc_pkg::HSC_S_HALT;
            end
         end
         hsc_pkg::HSC_S_HALT: begin
            // Requests sampled every core clock edge
            if (wake_hit && (halt_mode_r == hsc_pkg::HSC_STOP)) begin
               state_nxt = hsc_pkg::HSC_S_WARM;
            end else if (wake_hit) begin
               state_nxt = hsc_pkg::HSC_S_ACTIVE;   // Clock-aligned resume
            end
         end
         hsc_pkg::HSC_S_WARM: begin
            if (warm_done) begin
               state_nxt = hsc_pkg::HSC_S_ACTIVE;
            end
         end
         default: begin
            state_nxt = hsc_pkg::HSC_S_ACTIVE;
         end
      endcase
   end

   // Wake pulse: immediate on a pending flag, on release, or after warm-up
   logic wake_nxt;
   logic wake_srv_nxt;
   assign wake_nxt = ((state_r == hsc_pkg::HSC_S_ACTIVE) && halt_req && wake_hit) ||
                     ((state_r == hsc_pkg::HSC_S_HALT) && wake_hit &&
                      (halt_mode_r != hsc_pkg::HSC_STOP)) ||
                     warm_done;
   // Serviced only when nmi or interrupts enabled; flags stay otherwise
   // A stop wake uses the decision kept at warm-up start: the nmi pulse is gone by then
   logic warm_srv_r;   // Stop wake to be serviced
   assign wake_srv_nxt = wake_nxt && (warm_done ? warm_srv_r : (nmi_req || irq_enabled));

   // Per-mode gating while halted or warming
   logic in_halt;
   logic gate_all;
   logic gate_light;
   assign in_halt    = (state_nxt != hsc_pkg::HSC_S_ACTIVE);
   assign gate_all   = in_halt && (halt_mode_r != hsc_pkg::HSC_RUN);
   assign gate_light = in_halt && deep_or_stop;

   // Register read mux
   logic [7:0] rd_val;
   assign rd_val = (reg_addr == hsc_pkg::HSC_MODE_ADDR) ? mode_r :
                   (reg_addr == hsc_pkg::HSC_CFG_ADDR)  ? cfg_r  :
                   (reg_addr == hsc_pkg::HSC_STAT_ADDR) ?
                      {6'h00, rx_flag_r, ext0_req} : 8'h00;

   // Mode and config registers; reset to RUN, hold and warm clear
   always_ff @(posedge core_clk) begin
      if (rst) begin
         mode_r <= hsc_pkg::HSC_MODE_RST;
         cfg_r  <= hsc_pkg::HSC_CFG_RST;
      end else begin
         mode_r <= wr_mode ? reg_wdata : mode_r;
         cfg_r  <= wr_cfg  ? reg_wdata : cfg_r;
      end
   end

   // Request flags; a set in the clear cycle wins
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ext0_flag_r <= 1'b0;
         rx_flag_r   <= 1'b0;
         ext0_prev_r <= 1'b0;
         nmi_prev_r  <= 1'b0;
      end else begin
         ext0_prev_r <= ext0_s;
         nmi_prev_r  <= nmi_s;
         if (edge_mode && ext0_rise) begin
            ext0_flag_r <= 1'b1;
         end else if (to_level || ext0_clr) begin
            ext0_flag_r <= 1'b0;
         end
         // Receive flag ignores flag-clear writes
         if (serial_rx_irq) begin
            rx_flag_r <= 1'b1;
         end else if (rd_rxbuf) begin
            rx_flag_r <= 1'b0;
         end
      end
   end

   // State and latched halt mode; reset leaves stop with no warm-up
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_r     <= hsc_pkg::HSC_S_ACTIVE;
         halt_mode_r <= hsc_pkg::HSC_RUN;
      end else begin
         state_r     <= state_nxt;
         halt_mode_r <= (state_r == hsc_pkg::HSC_S_ACTIVE) ? sel_mode : halt_mode_r;
      end
   end

   // Service decision latched as the warm-up starts
   always_ff @(posedge core_clk) begin
      if (rst) begin
         warm_srv_r <= 1'b0;
      end else if (warm_start) begin
         warm_srv_r <= nmi_req || irq_enabled;
      end
   end

   // CPU-facing outputs and read data
   always_ff @(posedge core_clk) begin
      if (rst) begin
         wake         <= 1'b0;
         wake_service <= 1'b0;
         halted       <= 1'b0;
         reg_rdata    <= 8'h00;
      end else begin
         wake         <= wake_nxt;
         wake_service <= wake_srv_nxt;
         halted       <= in_halt;
         reg_rdata    <= reg_rd ? rd_val : 8'h00;
      end
   end

   // Clock and pin controls, all registered
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cpu_clk_en    <= 1'b1;
         timer_clk_en  <= 1'b1;
         serial_clk_en <= 1'b1;
         wdog_clk_en   <= 1'b1;
         osc_run       <= 1'b1;
         clk_pin_high  <= 1'b0;
         pins_float    <= 1'b0;
         pins_hold     <= 1'b0;
      end else begin
         cpu_clk_en    <= !gate_all;
         timer_clk_en  <= !gate_light;
         serial_clk_en <= !gate_light;
         // Watchdog runs in deep idle, stops in stop
         wdog_clk_en   <= !(in_halt && halt_mode_r == hsc_pkg::HSC_STOP);
         // Oscillator restarts as warm-up begins
         osc_run       <= !((state_nxt == hsc_pkg::HSC_S_HALT) &&
                            (halt_mode_r == hsc_pkg::HSC_STOP));
         clk_pin_high  <= gate_light && (halt_mode_r == hsc_pkg::HSC_DEEP);
         // Stop floats pins unless hold is set
         pins_float    <= in_halt && (halt_mode_r == hsc_pkg::HSC_STOP) && !hold_en;
         pins_hold     <= in_halt && (halt_mode_r == hsc_pkg::HSC_STOP) && hold_en;
      end
   end

endmodule
`default_nettype wire

// File: testbench/hsc_chk_monitor.sv
// Purpose: Port-level checks for the halt and standby controller.
// Assumes: Bound onto hsc_top; one core clock domain.
// Notes:   Warm-up hold is written for a short count of 8 cycles.
`timescale 1ns/1ps
`default_nettype none
module hsc_chk_monitor (
   input wire logic       core_clk,
   input wire logic       rst,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       timer_irqs,
   input wire logic       wake,
   input wire logic       wake_service,
   input wire logic       halted,
   input wire logic       cpu_clk_en,
   input wire logic       timer_clk_en,
   input wire logic       serial_clk_en,
   input wire logic       wdog_clk_en,
   input wire logic       osc_run,
   input wire logic       clk_pin_high,
   input wire logic       pins_float,
   input wire logic       pins_hold
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   // Read data only in the answer cycle
   property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer");
   // Reset leaves CPU clock and oscillator running, not halted, pins not floating
   property p_rst;
      disable iff (1'b0) rst |=> cpu_clk_en && osc_run && !halted && !pins_float;
   endproperty
   a_rst: assert property (p_rst) else $error("reset state wrong");
   // Wake is a single pulse that ends the halt
   property p_wake; wake |-> !halted ##1 !wake; endproperty
   a_wake: assert property (p_wake) else $error("wake pulse wrong");
   property p_srv; wake_service |-> wake; endproperty
   a_srv: assert property (p_srv) else $error("service without wake");
   // Run halt answers a timer request one cycle later
   property p_run; halted && cpu_clk_en && timer_irqs |=> wake; endproperty
   a_run: assert property (p_run) else $error("run halt missed request");
   // Deep idle keeps only oscillator and watchdog
   property p_deep;
      clk_pin_high |-> !cpu_clk_en && !timer_clk_en && !serial_clk_en && wdog_clk_en && osc_run;
   endproperty
   a_deep: assert property (p_deep) else $error("deep idle clocks wrong");
   // Light idle feeds timers, serial and watchdog only
   property p_light;
      halted && timer_clk_en && !cpu_clk_en |-> serial_clk_en && wdog_clk_en && !clk_pin_high;
   endproperty
   a_light: assert property (p_light) else $error("light idle clocks wrong");
   // Stop: oscillator off on entry, back on for warm-up; float or hold, never both
   property p_stop;
      pins_float || pins_hold |-> !cpu_clk_en && !(pins_float && pins_hold) &&
                                  (!$rose(pins_float || pins_hold) || !osc_run);
   endproperty
   a_stop: assert property (p_stop) else $error("stop pin state wrong");
   // Clock stays withheld through the warm-up after restart
   property p_warm; $rose(osc_run) && !$past(rst) |-> halted [*8]; endproperty
   a_warm: assert property (p_warm) else $error("warm-up cut short");
   // Long runs of activity mean CPU clock, timer clock and oscillator are on
   property p_act; (!halted [*3]) |-> cpu_clk_en && timer_clk_en && osc_run; endproperty
   a_act: assert property (p_act) else $error("clock off while active");
   c_srv: cover property (wake && wake_service);
   c_warm: cover property ($rose(osc_run));
   c_deep: cover property (clk_pin_high ##[1:20] wake);
endmodule
`default_nettype wire

// File: testbench/hsc_src_model.sv
// Purpose: Request sources facing the controller: ext zero and nmi pins.
// Assumes: Requests are one-cycle strobes from the bench.
// Notes:   Level request is held until the halt is released.
`timescale 1ns/1ps
`default_nettype none
module hsc_src_model (
   input  wire logic core_clk,
   input  wire logic rst,
   input  wire logic wake,
   input  wire logic lvl_req,
   input  wire logic edge_req,
   input  wire logic nmi_req,
   output logic      ext_irq_zero,
   output logic      nmi_pin
);
   logic       lvl_r;    // Level request pending
   logic [2:0] ecnt_r;   // Edge pulse length left
   logic [2:0] ncnt_r;   // Nmi low time left
   // Level stays at one until wake; noise drop would lose it
   always_ff @(posedge core_clk) begin
      if (rst || wake) begin
         lvl_r <= 1'b0;
      end else if (lvl_req) begin
         lvl_r <= 1'b1;
      end
      ecnt_r <= rst ? 3'h0 : edge_req ? 3'h4 : (ecnt_r != 3'h0) ? ecnt_r - 3'h1 : 3'h0;
      ncnt_r <= rst ? 3'h0 : nmi_req ? 3'h4 : (ncnt_r != 3'h0) ? ncnt_r - 3'h1 : 3'h0;
   end
   assign ext_irq_zero = lvl_r | (ecnt_r != 3'h0);
   // Nmi idles high, request is the falling edge
   assign nmi_pin = (ncnt_r == 3'h0);
endmodule
`default_nettype wire

// File: testbench/hsc_tb_top.sv
// Purpose: Directed bench for the halt and standby controller.
// Assumes: Warm-up counts cut to 8 and 16 cycles.
// Notes:   Stop exits are judged by a window, not an exact count.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module hsc_tb_top;
   localparam int WARM_SHORT = 8;    // Short warm-up for simulation
   localparam int WARM_LONG  = 16;   // Long warm-up for simulation
   logic        core_clk = 1'b0;
   logic        rst = 1'b1;
   logic [15:0] reg_addr = 16'h0000;
   logic [7:0]  reg_wdata = 8'h00;
   logic        reg_wr = 1'b0, reg_rd = 1'b0, halt_req = 1'b0, irq_enabled = 1'b0;
   logic        watchdog_irq = 1'b0, timer_irqs = 1'b0, serial_rx_irq = 1'b0;
   logic        lvl_req = 1'b0, edge_req = 1'b0, nmi_req = 1'b0;
   logic [7:0]  reg_rdata;
   logic        wake, wake_service, halted, ext_irq_zero, nmi_pin;
   logic        cpu_clk_en, timer_clk_en, serial_clk_en, wdog_clk_en;
   logic        osc_run, clk_pin_high, pins_float, pins_hold;
   int          error_cnt = 0;
   int          checks = 0;
   // 200 MHz core clock
   always #2.5 core_clk = ~core_clk;
   hsc_top #(.WARM_SHORT(WARM_SHORT), .WARM_LONG(WARM_LONG)) dut (
      .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .halt_req(halt_req),
      .irq_enabled(irq_enabled), .wake(wake), .wake_service(wake_service),
      .halted(halted), .nmi_pin(nmi_pin), .ext_irq_zero(ext_irq_zero),
      .ext_irq_one(1'b0), .watchdog_irq(watchdog_irq), .timer_irqs(timer_irqs),
      .serial_rx_irq(serial_rx_irq), .serial_tx_irq(1'b0), .irq_ack_ext0(1'b0),
      .cpu_clk_en(cpu_clk_en), .timer_clk_en(timer_clk_en),
      .serial_clk_en(serial_clk_en), .wdog_clk_en(wdog_clk_en), .osc_run(osc_run),
      .clk_pin_high(clk_pin_high), .pins_float(pins_float), .pins_hold(pins_hold));
   hsc_src_model u_src (
      .core_clk(core_clk), .rst(rst), .wake(wake), .lvl_req(lvl_req),
      .edge_req(edge_req), .nmi_req(nmi_req), .ext_irq_zero(ext_irq_zero),
      .nmi_pin(nmi_pin));
   task automatic complete_run;
      $display("checks=%0d error_cnt=%0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr    <= 1'b0;
   endtask
   // Data is taken in the one cycle it stands
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd   <= 1'b0;
      #1;
      d = reg_rdata;
   endtask
   task automatic halt(input logic ie);
      @(posedge core_clk);
      halt_req    <= 1'b1;
      irq_enabled <= ie;
      @(posedge core_clk);
      halt_req    <= 1'b0;
      #1;
   endtask
   // Bounded wait for the wake pulse
   task automatic ww(input int n, output int c);
      c = 0;
      while (wake !== 1'b1 && c < n) begin
         @(posedge core_clk);
         #1;
         c++;
      end
      `CHK(wake, 1'b1)
   endtask
   task automatic strobe_edge;
      @(posedge core_clk);
      edge_req <= 1'b1;
      @(posedge core_clk);
      edge_req <= 1'b0;
      repeat (8) @(posedge core_clk);
   endtask
   task automatic t_regs;
      logic [7:0] v;
      rd(hsc_pkg::HSC_MODE_ADDR, v);
      `CHK(v, hsc_pkg::HSC_MODE_RST)
      wr(hsc_pkg::HSC_MODE_ADDR, 8'h1d);
      rd(hsc_pkg::HSC_MODE_ADDR, v);
      `CHK(v, 8'h1d)
      rd(16'h1234, v);
      `CHK(v, 8'h00)
      wr(hsc_pkg::HSC_MODE_ADDR, 8'h00);
      $display("t_regs done");
   endtask
   task automatic t_run;
      int c;
      halt(1'b1);
      `CHK(halted, 1'b1)
      @(posedge core_clk);
      timer_irqs <= 1'b1;
      ww(4, c);
      `CHK(wake_service, 1'b1)
      @(posedge core_clk);
      timer_irqs <= 1'b0;
      $display("t_run done");
   endtask
   task automatic t_light;
      int c;
      wr(hsc_pkg::HSC_MODE_ADDR, 8'h0c);
      halt(1'b0);
      @(posedge core_clk);
      #1;
      `CHK({cpu_clk_en, timer_clk_en, serial_clk_en}, 3'b011)
      @(posedge core_clk);
      watchdog_irq <= 1'b1;
      ww(4, c);
      `CHK(wake_service, 1'b0)
      @(posedge core_clk);
      watchdog_irq <= 1'b0;
      $display("t_light done");
   endtask
   task automatic t_deep;
      int c;
      wr(hsc_pkg::HSC_MODE_ADDR, 8'h08);
      halt(1'b0);
      @(posedge core_clk);
      #1;
      `CHK(clk_pin_high, 1'b1)
      repeat (10) begin
         @(posedge core_clk);
         watchdog_irq <= 1'b1;
         #1;
         `CHK(wake, 1'b0)
      end
      @(posedge core_clk);
      watchdog_irq <= 1'b0;
      lvl_req      <= 1'b1;
      @(posedge core_clk);
      lvl_req      <= 1'b0;
      ww(8, c);
      `CHK(wake_service, 1'b0)
      $display("t_deep done");
   endtask
   task automatic t_stop(input logic [7:0] m, input int n);
      int c;
      wr(hsc_pkg::HSC_MODE_ADDR, m);
      halt(1'b0);
      @(posedge core_clk);
      #1;
      `CHK({pins_float, pins_hold, osc_run}, {~m[0], m[0], 1'b0})
      @(posedge core_clk);
      nmi_req <= 1'b1;
      @(posedge core_clk);
      nmi_req <= 1'b0;
      ww(n + 12, c);
      `CHK(c >= n, 1'b1)
      `CHK(wake_service, 1'b1)
      $display("t_stop done");
   endtask
   task automatic t_stop_rst;
      logic [7:0] v;
      wr(hsc_pkg::HSC_MODE_ADDR, 8'h04);
      halt(1'b0);
      @(posedge core_clk);
      rst <= 1'b1;
      repeat (4) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      #1;
      `CHK({halted, cpu_clk_en, osc_run}, 3'b011)
      rd(hsc_pkg::HSC_MODE_ADDR, v);
      `CHK(v, 8'h00)
      $display("t_stop_rst done");
   endtask
   task automatic t_flags;
      logic [7:0] v;
      @(posedge core_clk);
      serial_rx_irq <= 1'b1;
      @(posedge core_clk);
      serial_rx_irq <= 1'b0;
      wr(hsc_pkg::HSC_FCLR_ADDR, hsc_pkg::HSC_CLR_RX);
      halt(1'b0);
      `CHK({wake, halted}, 2'b10)
      rd(hsc_pkg::HSC_STAT_ADDR, v);
      `CHK(v[hsc_pkg::HSC_ST_RX], 1'b1)
      rd(hsc_pkg::HSC_RXBUF_ADDR, v);
      rd(hsc_pkg::HSC_STAT_ADDR, v);
      `CHK(v[hsc_pkg::HSC_ST_RX], 1'b0)
      wr(hsc_pkg::HSC_CFG_ADDR, 8'h01);
      strobe_edge();
      rd(hsc_pkg::HSC_STAT_ADDR, v);
      `CHK(v[hsc_pkg::HSC_ST_EXT0], 1'b1)
      wr(hsc_pkg::HSC_CFG_ADDR, 8'h00);
      rd(hsc_pkg::HSC_STAT_ADDR, v);
      `CHK(v[hsc_pkg::HSC_ST_EXT0], 1'b0)
      wr(hsc_pkg::HSC_CFG_ADDR, 8'h01);
      rd(hsc_pkg::HSC_STAT_ADDR, v);
      `CHK(v[hsc_pkg::HSC_ST_EXT0], 1'b0)
      strobe_edge();
      wr(hsc_pkg::HSC_FCLR_ADDR, hsc_pkg::HSC_CLR_EXT0);
      rd(hsc_pkg::HSC_STAT_ADDR, v);
      `CHK(v[hsc_pkg::HSC_ST_EXT0], 1'b0)
      $display("t_flags done");
   endtask
   // Run is about two hundred cycles; this span is far beyond it
   initial begin
      #50000;
      error_cnt++;
      complete_run();
   end
   initial begin
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      t_regs();
      t_run();
      t_light();
      t_deep();
      t_stop(8'h04, WARM_SHORT);
      t_stop(8'h15, WARM_LONG);
      t_stop_rst();
      t_flags();
      complete_run();
   end
endmodule
bind hsc_top hsc_chk_monitor u_mon (
   .core_clk(core_clk), .rst(rst), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .timer_irqs(timer_irqs), .wake(wake), .wake_service(wake_service), .halted(halted),
   .cpu_clk_en(cpu_clk_en), .timer_clk_en(timer_clk_en), .serial_clk_en(serial_clk_en),
   .wdog_clk_en(wdog_clk_en), .osc_run(osc_run), .clk_pin_high(clk_pin_high),
   .pins_float(pins_float), .pins_hold(pins_hold));
`default_nettype wire
